// ### rtl/lbd_local_bus.sv
/*
  Address phase, chip select decode and termination of the local bus.
  Assumes synchronous inputs, a board that holds the strap levels on
  ad_in[2:0] at the rising edge of reset_input_n_in, and a testbench that
  resolves the shared lines from ad_oe_out.
*/
`timescale 1ns/1ps
module lbd_local_bus (
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    input  wire logic               ce_in,
    input  wire logic               reset_input_n_in,
    input  wire logic               cfg_wr_in,
    input  wire logic [2:0]         cfg_sel_in,
    input  wire lbd_pkg::lbd_cs_cfg_t cfg_in,
    input  wire logic               req_valid_in,
    input  wire lbd_pkg::lbd_req_t  req_in,
    input  wire logic [31:0]        ad_in,
    input  wire logic               xfer_ack_n_in,
    output logic                    req_ready_out,
    output logic                    done_out,
    output logic [31:0]             rdata_out,
    output logic [31:0]             ad_out,
    output logic [3:0]              ad_oe_out,
    output logic                    xfer_begin_n_out,
    output logic                    rw_out,
    output logic [1:0]              xfer_size_code_out,
    output logic                    burst_out,
    output logic [5:0]              ext_select_n_out,
    output logic                    boot_global_out
);
    import lbd_pkg::*;

    lbd_cs_cfg_t cfg_r [NUM_CS];
    lbd_cs_cfg_t cur_r;
    lbd_cs_cfg_t sel_cfg;
    lbd_state_t  state_r;
    logic [5:0]  hit;
    logic [5:0]  hit_sel;
    logic [3:0]  wcnt_r;
    logic        any_r;
    logic        rstn_d_r;
    logic        take;
    logic        term;

    function automatic logic [3:0] lane_mask(input logic [1:0] ps);
        case (ps)
            PORT_8:  lane_mask = LANES_8;
            PORT_16: lane_mask = LANES_16;
            default: lane_mask = LANES_32;
        endcase
    endfunction

    // Narrow ports sit on the upper lanes: an 8-bit port on AD[31:24], a 16-bit port on AD[31:16]
    function automatic logic [31:0] lane_out(input logic [1:0] ps,
                                             input logic [31:0] d);
        case (ps)
            PORT_8:  lane_out = {d[7:0], 24'h0};
            PORT_16: lane_out = {d[15:0], 16'h0};
            default: lane_out = d;
        endcase
    endfunction

    function automatic logic [31:0] lane_in(input logic [1:0] ps,
                                            input logic [31:0] d);
        case (ps)
            PORT_8:  lane_in = {24'h0, d[31:24]};
            PORT_16: lane_in = {16'h0, d[31:16]};
            default: lane_in = d;
        endcase
    endfunction
    assign take = req_valid_in && req_ready_out && state_r == ST_IDLE;
    // Lowest hit wins so overlapping windows never drive two selects
    always_comb
    begin
        hit     = '0;
        hit_sel = '0;
        sel_cfg = CS_CFG_RST;
        for (int i = 0; i < NUM_CS; i++)
        begin
            hit[i] = cfg_r[i].valid &&
                     (((req_in.addr[31:16] ^ cfg_r[i].base)
                       & ~cfg_r[i].mask) == 16'h0);
        end
        if (boot_global_out)
        begin
            hit_sel = CS_BOOT_HIT;
            sel_cfg = cfg_r[0];
        end
        else
        begin
            for (int i = NUM_CS - 1; i >= 0; i--)
            begin
                if (hit[i])
                begin
                    hit_sel = 6'(1 << i);
                    sel_cfg = cfg_r[i];
                end
            end
        end
    end
    // Strap capture and configuration store
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < NUM_CS; i++)
                cfg_r[i] <= CS_CFG_RST;
            boot_global_out <= 1'b1;
            rstn_d_r <= 1'b0;
        end
        else if (ce_in)
        begin
            rstn_d_r <= reset_input_n_in;
            if (!reset_input_n_in)
            begin
                for (int i = 0; i < NUM_CS; i++)
                    cfg_r[i] <= CS_CFG_RST;
                boot_global_out <= 1'b1;
            end
            else if (!rstn_d_r)
            begin
                cfg_r[0].valid     <= 1'b1;
                cfg_r[0].wait_cnt  <= BOOT_WAIT_RST;
                cfg_r[0].port_size <= ad_in[STRAP_PS_LSB +: 2];
                cfg_r[0].auto_ack  <= ad_in[STRAP_AA_BIT];
            end
            else if (cfg_wr_in && cfg_sel_in < 3'(NUM_CS))
            begin
                cfg_r[cfg_sel_in] <= cfg_in;
                if (cfg_sel_in == 3'h0)
                    boot_global_out <= 1'b0;
            end
        end
    end
    // Only the wait count and external ack decide the end of a cycle
    assign term = (cur_r.auto_ack || !any_r) ? (wcnt_r == 4'h0)
                                              : !xfer_ack_n_in;
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r            <= ST_IDLE;
            cur_r              <= CS_CFG_RST;
            any_r              <= 1'b0;
            wcnt_r             <= 4'h0;
            req_ready_out      <= 1'b0;
            done_out           <= 1'b0;
            rdata_out          <= 32'h0;
            ad_out             <= 32'h0;
            ad_oe_out          <= 4'h0;
            xfer_begin_n_out   <= 1'b1;
            rw_out             <= 1'b1;
            xfer_size_code_out <= SIZE_LONG;
            burst_out          <= 1'b0;
            ext_select_n_out   <= CS_NONE;
        end
        else if (ce_in)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    done_out      <= 1'b0;
                    req_ready_out <= reset_input_n_in && rstn_d_r;
                    if (take)
                    begin
                        req_ready_out      <= 1'b0;
                        ad_out             <= req_in.addr;
                        ad_oe_out          <= LANES_32;
                        xfer_begin_n_out   <= 1'b0;
                        rw_out             <= !req_in.write;
                        xfer_size_code_out <= req_in.size;
                        burst_out <= sel_cfg.burst
                                     && req_in.size == SIZE_LINE;
                        ext_select_n_out   <= ~hit_sel;
                        cur_r              <= sel_cfg;
                        any_r              <= hit_sel != 6'h0;
                        wcnt_r             <= sel_cfg.wait_cnt;
                        state_r            <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    xfer_begin_n_out <= 1'b1;
                    if (!rw_out)
                    begin
                        ad_out    <= lane_out(cur_r.port_size,
                                              req_in.wdata);
                        ad_oe_out <= lane_mask(cur_r.port_size);
                    end
                    else
                        ad_oe_out <= 4'h0;
                    state_r <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (term)
                    begin
                        ext_select_n_out <= CS_NONE;
                        rdata_out <= rw_out
                                     ? lane_in(cur_r.port_size, ad_in)
                                     : 32'h0;
                        done_out  <= 1'b1;
                        state_r   <= ST_HOLD;
                    end
                    else if (wcnt_r != 4'h0)
                        wcnt_r <= wcnt_r - 4'h1;
                end
                ST_HOLD:
                begin
                    // Write data stays one clock past the select release
                    done_out      <= 1'b0;
                    ad_oe_out     <= 4'h0;
                    rw_out        <= 1'b1;
                    req_ready_out <= reset_input_n_in;
                    state_r       <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
    default clocking cb @(posedge mclk_in iff ce_in);
    endclocking
    default disable iff (rst_in);
    property p_addr_phase;
        take |=> ad_out == $past(req_in.addr) && ad_oe_out == LANES_32;
    endproperty
    a_addr_phase: assert property (p_addr_phase)
        else $error("address phase not driven");
    property p_lanes;
        state_r == ST_DATA |-> ad_oe_out == (rw_out ? 4'h0
                               : lane_mask(cur_r.port_size));
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("data lanes exceed port size");
    property p_select;
        take |=> (~ext_select_n_out) == $past(hit_sel);
    endproperty
    a_select: assert property (p_select)
        else $error("wrong chip select asserted");
    property p_cfg_store;
        reset_input_n_in && rstn_d_r && cfg_wr_in && cfg_sel_in == 3'h2
            |=> cfg_r[2] == $past(cfg_in);
    endproperty
    a_cfg_store: assert property (p_cfg_store)
        else $error("select config not stored");
    property p_reset_clear;
        !reset_input_n_in |=> boot_global_out && !cfg_r[1].valid
                              && !cfg_r[5].valid;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("config not cleared in reset");
    property p_global;
        take && boot_global_out |=> ext_select_n_out == ~CS_BOOT_HIT;
    endproperty
    a_global: assert property (p_global)
        else $error("boot select not global");
    property p_strap;
        reset_input_n_in && !rstn_d_r |=> cfg_r[0].valid
            && cfg_r[0].port_size == $past(ad_in[1:0])
            && cfg_r[0].auto_ack == $past(ad_in[2]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not captured");
    property p_start_pulse;
        $fell(xfer_begin_n_out) |=> xfer_begin_n_out [*2];
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start strobe not one clock");
    property p_dir;
        take |=> rw_out == !$past(req_in.write) ##1 $stable(rw_out);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction changed within cycle");
    property p_ext_ack;
        state_r == ST_DATA && any_r && !cur_r.auto_ack && !xfer_ack_n_in
            |=> done_out && ext_select_n_out == CS_NONE;
    endproperty
    a_ext_ack: assert property (p_ext_ack)
        else $error("external ack not honoured");
    property p_size;
        take |=> xfer_size_code_out == $past(req_in.size);
    endproperty
    a_size: assert property (p_size)
        else $error("size code mismatch");
    property p_no_hit;
        take && !boot_global_out && hit == 6'h0
            |=> ext_select_n_out == CS_NONE;
    endproperty
    a_no_hit: assert property (p_no_hit)
        else $error("select asserted with no hit");
    c_read: cover property (take && !req_in.write ##[3:20] done_out);
    c_write8: cover property (take && req_in.write
                              && sel_cfg.port_size == PORT_8);
    c_ext_ack: cover property (state_r == ST_DATA && !cur_r.auto_ack
                               && !xfer_ack_n_in);
    c_no_hit: cover property (take && !boot_global_out && hit == 6'h0);
endmodule // lbd_local_bus

// ### rtl/lbd_pkg.sv
/*
  Constants, field layouts and carrier types for the local bus chip select
  decoder. Assumes one bus clock and that all inputs are synchronous to it.
*/
// Summary of operation
// - The first clock of each bus cycle drives the full 32-bit address.
// - The data phase uses only the byte lanes of the selected port size.
// - Six selects; outside boot mode each is asserted only when the address hits its window.
// - Each select has base, mask, port size, burst, waits and ack source.
// - Reset clears every select; only select zero comes up usable.
// - After reset the boot select matches any address until reprogrammed.
// - Boot port size and ack source are taken from AD[2:0] at reset rise.
// - The active-low start strobe is low for exactly one clock per cycle.
// - Direction is high through reads and low through writes.
// - A cycle ends on the internal auto acknowledge or the external one.
package lbd_pkg;
    localparam int          NUM_CS      = 6;
    localparam logic [1:0]  SIZE_LONG   = 2'h0;
    localparam logic [1:0]  SIZE_BYTE   = 2'h1;
    localparam logic [1:0]  SIZE_WORD   = 2'h2;
    localparam logic [1:0]  SIZE_LINE   = 2'h3;
    localparam logic [1:0]  PORT_32     = 2'h0;
    localparam logic [1:0]  PORT_8      = 2'h1;
    localparam logic [1:0]  PORT_16     = 2'h2;
    localparam logic [3:0]  LANES_32    = 4'hf;
    localparam logic [3:0]  LANES_16    = 4'hc;
    localparam logic [3:0]  LANES_8     = 4'h8;
    localparam int          STRAP_PS_LSB = 0;
    localparam int          STRAP_AA_BIT = 2;
    localparam logic [3:0]  BOOT_WAIT_RST = 4'hf;
    localparam logic [5:0]  CS_NONE     = 6'h3f;
    localparam logic [5:0]  CS_BOOT_HIT = 6'h01;

    typedef struct packed {
        logic        valid;
        logic [15:0] base;
        logic [15:0] mask;
        logic [1:0]  port_size;
        logic        burst;
        logic [3:0]  wait_cnt;
        logic        auto_ack;
    } lbd_cs_cfg_t;

    localparam lbd_cs_cfg_t CS_CFG_RST = '0;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic [31:0] wdata;
        logic [1:0]  size;
    } lbd_req_t;

    typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD} lbd_state_t;
endpackage

// ### verif/lbd_local_bus_test.sv
/*
  Self-checking bench for the local bus chip select decoder.
  Assumes the design carries its own assertions; inputs move at negedge.
*/
`timescale 1ns/1ps
module lbd_local_bus_test;
    import lbd_pkg::*;
    localparam logic [31:0] WD  = 32'h1122_3344;
    localparam logic [31:0] PAT = 32'ha5c3_5a96;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic        reset_input_n_in = 1'b0;
    logic        cfg_wr_in = 1'b0;
    logic [2:0]  cfg_sel_in = 3'h0;
    lbd_cs_cfg_t cfg_in = CS_CFG_RST;
    logic        req_valid_in = 1'b0;
    lbd_req_t    req_in = '0;
    logic [31:0] ad_in, rdata_out, ad_out, ad_drv;
    logic        xfer_ack_n_in, req_ready_out, done_out, rw_out;
    logic        xfer_begin_n_out, burst_out, boot_global_out;
    logic [3:0]  ad_oe_out;
    logic [1:0]  xfer_size_code_out;
    logic [5:0]  ext_select_n_out;
    logic [2:0]  strap = 3'h5;
    logic        ext_ack = 1'b0;
    logic [3:0]  ack_wait = 4'h0;
    int          num_errors = 0;
    int          tests_run = 0;

    always #50 mclk_in = ~mclk_in;
    always_comb
        for (int i = 0; i < 4; i++)
            ad_in[8*i +: 8] = ad_oe_out[i] ? ad_out[8*i +: 8]
                                           : ad_drv[8*i +: 8];

    lbd_local_bus lbd_local_bus_inst (.mclk_in, .rst_in, .ce_in,
        .reset_input_n_in, .cfg_wr_in, .cfg_sel_in, .cfg_in, .req_valid_in,
        .req_in, .ad_in, .xfer_ack_n_in, .req_ready_out, .done_out,
        .rdata_out, .ad_out, .ad_oe_out, .xfer_begin_n_out, .rw_out,
        .xfer_size_code_out, .burst_out, .ext_select_n_out,
        .boot_global_out);
    lbd_mem_model lbd_mem_model_inst (.mclk_in, .rst_in, .reset_input_n_in,
        .strap_in(strap), .sel_n_in(ext_select_n_out), .rw_in(rw_out),
        .begin_n_in(xfer_begin_n_out), .ad_oe_in(ad_oe_out),
        .ext_ack_in(ext_ack), .ack_wait_in(ack_wait), .rd_pat_in(PAT),
        .ad_drv_out(ad_drv), .xfer_ack_n_out(xfer_ack_n_in));

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bound(input int k, input int lim);
        if (k >= lim)
        begin
            num_errors++;
            summarize();
        end
    endtask

    task automatic cfg(input logic [2:0] s, input lbd_cs_cfg_t c);
        @(negedge mclk_in);
        cfg_sel_in = s;
        cfg_in = c;
        cfg_wr_in = 1'b1;
        @(negedge mclk_in);
        cfg_wr_in = 1'b0;
    endtask

    // One whole transfer; pl is the port's lane set, 0 skips data checks
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [1:0] sz, input logic [5:0] es,
                        input int lat, input logic [3:0] pl, input logic eb);
        int          k;
        int          sh;
        logic [31:0] m;
        m = {{8{pl[3]}}, {8{pl[2]}}, {8{pl[1]}}, {8{pl[0]}}};
        sh = 32 - 8 * $countones(pl);
        k = 0;
        @(negedge mclk_in);
        req_in = '{addr: a, write: w, wdata: WD, size: sz};
        req_valid_in = 1'b1;
        while (req_ready_out !== 1'b1 && k < 100)
        begin
            @(negedge mclk_in);
            k++;
        end
        bound(k, 100);
        @(negedge mclk_in);
        chk(ad_out, a);
        chk({ad_oe_out, xfer_begin_n_out, rw_out}, {4'hf, 1'b0, ~w});
        chk(xfer_size_code_out, sz);
        chk(ext_select_n_out, es);
        chk(burst_out, eb);
        @(negedge mclk_in);
        chk({xfer_begin_n_out, rw_out}, {1'b1, ~w});
        chk(ad_oe_out, w ? pl : 4'h0);
        if (w)
            chk(ad_out & m, (WD << sh) & m);
        k = 2;
        while (done_out !== 1'b1 && k < 40)
        begin
            @(negedge mclk_in);
            k++;
        end
        bound(k, 40);
        chk(k, lat);
        chk(ext_select_n_out, 6'h3f);
        if (!w && pl != 4'h0)
            chk(rdata_out & (m >> sh), PAT >> sh);
        req_valid_in = 1'b0;
    endtask

    initial
    begin
        repeat (20) @(negedge mclk_in);
        chk({ext_select_n_out, boot_global_out, ad_oe_out},
            {6'h3f, 1'b1, 4'h0});
        rst_in = 1'b0;
        @(negedge mclk_in);
        reset_input_n_in = 1'b1;
        xfer(32'h7654_0000, 1'b0, 2'h0, 6'h3e, 18, 4'h8, 1'b0);
        xfer(32'h7654_0000, 1'b1, 2'h1, 6'h3e, 18, 4'h8, 1'b0);
        $display("test boot_global finished");
        cfg(3'h1, '{1'b1, 16'h1000, 16'h00ff, PORT_16, 1'b1, 4'h2,
            1'b1});
        // Overlaps select 1, so the lower index must still win
        cfg(3'h2, '{1'b1, 16'h1000, 16'h00ff, PORT_8, 1'b0, 4'h0,
            1'b1});
        cfg(3'h0, '{1'b1, 16'h0000, 16'h000f, PORT_32, 1'b0, 4'h0,
            1'b0});
        cfg(3'h6, '{1'b1, 16'h8000, 16'h0000, PORT_32, 1'b0, 4'h0,
            1'b1});
        chk(boot_global_out, 1'b0);
        for (int s = 0; s < 4; s++)
            xfer(32'h1034_0000, 1'b1, s[1:0], 6'h3d, 5, 4'hc, s == 3);
        ext_ack = 1'b1;
        for (int w = 0; w < 3; w += 2)
        begin
            ack_wait = w[3:0];
            xfer(32'h0005_0000, 1'b0, 2'h0, 6'h3e, 3 + w, 4'hf, 1'b0);
        end
        xfer(32'h8000_0000, 1'b0, 2'h0, 6'h3f, 3, 4'h0, 1'b0);
        $display("test windows finished");
        // A low enable must freeze the hold state and the select setup
        ce_in = 1'b0;
        reset_input_n_in = 1'b0;
        strap = 3'h0;
        repeat (2) @(negedge mclk_in);
        chk({boot_global_out, done_out}, 2'h1);
        ce_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        chk({boot_global_out, req_ready_out}, 2'h2);
        reset_input_n_in = 1'b1;
        ack_wait = 4'h1;
        xfer(32'h1034_0000, 1'b0, 2'h0, 6'h3e, 4, 4'hf, 1'b0);
        $display("test restrap finished");
        summarize();
    end
endmodule // lbd_local_bus_test

// ### verif/lbd_mem_model.sv
/*
  Boot memory and peripheral model on the far side of the local bus.
  Assumes the bench resolves the shared lines from the lane enables.
*/
`timescale 1ns/1ps
module lbd_mem_model (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        reset_input_n_in,
    input  wire logic [2:0]  strap_in,
    input  wire logic [5:0]  sel_n_in,
    input  wire logic        rw_in,
    input  wire logic        begin_n_in,
    input  wire logic [3:0]  ad_oe_in,
    input  wire logic        ext_ack_in,
    input  wire logic [3:0]  ack_wait_in,
    input  wire logic [31:0] rd_pat_in,
    output logic      [31:0] ad_drv_out,
    output logic             xfer_ack_n_out
);
    logic [31:0] junk_r;
    logic [3:0]  cnt_r;
    logic        rin_d_r;
    logic        hit;

    assign hit = (sel_n_in != 6'h3f);
    always_comb
    begin
        // Released lines show the inverse of the last value, never a hold
        ad_drv_out = junk_r;
        if (rw_in && hit && ad_oe_in == 4'h0)
            ad_drv_out = rd_pat_in;
        if (!reset_input_n_in || !rin_d_r)
            ad_drv_out[2:0] = strap_in;
    end
    // Ack stays low while selected, so read data is held until it is seen
    assign xfer_ack_n_out = !(ext_ack_in && hit && begin_n_in
                              && cnt_r >= ack_wait_in);

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            junk_r  <= 32'h0f0f_0f0f;
            cnt_r   <= 4'h0;
            rin_d_r <= 1'b0;
        end
        else
        begin
            junk_r  <= ~ad_drv_out;
            rin_d_r <= reset_input_n_in;
            if (!begin_n_in)
                cnt_r <= 4'h0;
            else if (cnt_r != 4'hf)
                cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // lbd_mem_model
